// File: hdl/hsa_defines.svh
/*
 * Register map, field positions, reset values and fixed-point constants
 * for the hue/saturation adjust stage. Assumes a plain register port
 * with 8-bit byte address and 32-bit data.
 */
// Overview of operation
// - Six colors each keep a hue and saturation pair; selector picks one.
// - Feature off bypasses the stage; on applies stored adjustments.
// - Hue value spans -1.0 to +0.99219 as signed fixed point.
// - Hue code is signed -128..+127, +64 means +0.5, -128 means -1.0.
// - Saturation value spans 0.0 to +1.99219 as unsigned fixed point.
// - Saturation code 0..255, 0 gives zero gain, 128 unity gain.
// - Each color's adjustment acts only on pixels where it is primary or secondary.
// - Adjusting a color's hue partly moves it toward one hexagon neighbour, chosen by the sign.
// - Hue is a rotation, at most fully into the adjacent corner.
// - Negative hue rotates red toward yellow, positive toward magenta.
// - More saturation adds colour; minimum saturation leaves plain gray.
// - Bayer format without enhance allow leaves the stage without effect.
// - Bayer format with enhance allow adjusts the raw RGB data.
// - Non-Bayer formats ignore the enhance allow bit.
// - Restore command reloads all pairs with the illuminant's defaults.
// - Custom illuminant loads neutral values that change nothing.
`ifndef HSA_DEFINES_SVH
`define HSA_DEFINES_SVH

`define HSA_REG_CTRL     8'h00
`define HSA_REG_SEL      8'h04
`define HSA_REG_HUE      8'h08
`define HSA_REG_SAT      8'h0C
`define HSA_REG_ILLUM    8'h10
`define HSA_REG_RESTORE  8'h14
`define HSA_REG_STATUS   8'h18

`define HSA_CTRL_ON      0
`define HSA_CTRL_ALLOW   1
`define HSA_CTRL_BAYER   2
`define HSA_CTRL_W       3
`define HSA_CTRL_RST     3'h0

`define HSA_HUE_NEUTRAL  8'h00
`define HSA_SAT_UNITY    8'h80
`define HSA_HUE_FULL     9'h080
`define HSA_FRAC_SHIFT   7
`define HSA_CH_MAX       12'h0FF
`define HSA_NUM_COLORS   6
`define HSA_LAST_COLOR   3'h5

`endif

// File: hdl/hsa_pkg.sv
/*
 * Types shared by the hue/saturation adjust stage.
 * Assumes 8-bit RGB components.
 */
package hsa_pkg;
    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } hsa_pix_t;

    typedef struct packed {
        logic signed [7:0] hue;
        logic [7:0]        sat;
    } hsa_adj_t;

    typedef enum logic [2:0] {
        HSA_IL_OFF,
        HSA_IL_TUNGSTEN,
        HSA_IL_DAYLIGHT,
        HSA_IL_D6500,
        HSA_IL_CUSTOM
    } hsa_illum_t;
endpackage : hsa_pkg

// File: hdl/hsa_top.sv
/*
 * Hue/saturation adjust stage: register file, frame-synchronous settings
 * and a three-stage pixel pipeline. Assumes white-balanced RGB input,
 * one pixel per clock with a start-of-frame marker, and a register master
 * that never needs a wait.
 */
// Local design decisions: the strobed register port and the placing of the registers.
`include "hsa_defines.svh"

module hsa_top
    import hsa_pkg::*;
#(
    parameter int unsigned NUM_COLORS = 6,
    parameter hsa_adj_t    DEF_TUNG   = '{hue: 8'h00, sat: 8'h80},
    parameter hsa_adj_t    DEF_DAY    = '{hue: 8'h00, sat: 8'h80},
    parameter hsa_adj_t    DEF_D6500  = '{hue: 8'h00, sat: 8'h80}
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Pixel input
    input  wire logic        pix_valid_i,
    input  wire logic        sof_i,
    input  wire hsa_pix_t    pix_i,
    // Pixel output
    output logic             pix_valid_o,
    output logic             sof_o,
    output hsa_pix_t         pix_o
);

    if (NUM_COLORS != `HSA_NUM_COLORS) begin : g_chk
        $error("hsa_top serves exactly six hexagon colors");
    end

    localparam hsa_adj_t NEUTRAL = '{hue: `HSA_HUE_NEUTRAL,
                                     sat: `HSA_SAT_UNITY};

    // Hue is signed 1.7 fixed point, saturation 1.7 fixed point
    function automatic logic [2:0] hsa_nb(input logic [2:0] idx,
                                          input logic       neg);
        logic [2:0] r;
        r = idx;
        if (neg) begin
            r = (idx == `HSA_LAST_COLOR) ? 3'h0 : idx + 3'h1;
        end else begin
            r = (idx == 3'h0) ? `HSA_LAST_COLOR : idx - 3'h1;
        end
        return r;
    endfunction : hsa_nb

    // Returns {stay, move}; move goes to the rotation neighbour
    function automatic logic [19:0] hsa_split(input logic [7:0] c,
                                              input hsa_adj_t   a);
        logic [15:0] gain;
        logic [8:0]  amt;
        logic [8:0]  mag;
        logic [17:0] keep;
        logic [9:0]  stay;
        gain = c * a.sat;
        amt  = gain[15:`HSA_FRAC_SHIFT];
        // Explicit 9-bit negate so code -128 gives magnitude 128
        mag  = a.hue[7] ? (9'h100 - {1'b0, a.hue}) : {1'b0, a.hue};
        keep = amt * (`HSA_HUE_FULL - mag);
        stay = keep[16:`HSA_FRAC_SHIFT];
        return {stay, 10'({1'b0, amt} - stay)};
    endfunction : hsa_split

    // Control and settings
    logic [`HSA_CTRL_W-1:0] ctrl;
    logic [2:0]             sel;
    hsa_illum_t             illum;
    hsa_adj_t               stage_tab [NUM_COLORS];
    hsa_adj_t               live_tab  [NUM_COLORS];
    logic                   live_active;
    logic                   pend;

    // Register decode
    wire wr_ctrl    = wr_i && (addr_i == `HSA_REG_CTRL);
    wire wr_sel     = wr_i && (addr_i == `HSA_REG_SEL)
                      && (wdata_i[2:0] <= `HSA_LAST_COLOR);
    wire wr_hue     = wr_i && (addr_i == `HSA_REG_HUE);
    wire wr_sat     = wr_i && (addr_i == `HSA_REG_SAT);
    wire wr_illum   = wr_i && (addr_i == `HSA_REG_ILLUM);
    wire wr_restore = wr_i && (addr_i == `HSA_REG_RESTORE);
    wire any_wr     = wr_ctrl | wr_sel | wr_hue | wr_sat
                      | wr_illum | wr_restore;
    wire frame_go   = pix_valid_i && sof_i;

    // Choosing an illuminant also loads its defaults
    wire        load_dflt = wr_restore || wr_illum;
    wire [2:0]  dsrc_raw  = wr_illum ? wdata_i[2:0] : illum;
    wire hsa_adj_t dflt   =
        (dsrc_raw == 3'(HSA_IL_TUNGSTEN)) ? DEF_TUNG  :
        (dsrc_raw == 3'(HSA_IL_DAYLIGHT)) ? DEF_DAY   :
        (dsrc_raw == 3'(HSA_IL_D6500))    ? DEF_D6500 :
        NEUTRAL;

    wire next_active = ctrl[`HSA_CTRL_ON]
        && (!ctrl[`HSA_CTRL_BAYER] || ctrl[`HSA_CTRL_ALLOW]);

    // Readback of the selected colour's pair
    wire hsa_adj_t cur = stage_tab[sel];
    wire [31:0] rd_mux =
        (addr_i == `HSA_REG_CTRL)   ? {29'h0000_0000, ctrl}          :
        (addr_i == `HSA_REG_SEL)    ? {29'h0000_0000, sel}           :
        (addr_i == `HSA_REG_HUE)    ? {24'h00_0000, cur.hue}         :
        (addr_i == `HSA_REG_SAT)    ? {24'h00_0000, cur.sat}         :
        (addr_i == `HSA_REG_ILLUM)  ? {29'h0000_0000, illum}         :
        (addr_i == `HSA_REG_STATUS) ? {30'h0000_0000, pend,
                                       live_active}                  :
        32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl    <= `HSA_CTRL_RST;
            sel     <= 3'h0;
            illum   <= HSA_IL_OFF;
            rdata_o <= 32'h0000_0000;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wdata_i[`HSA_CTRL_W-1:0];
            end
            if (wr_sel) begin
                sel <= wdata_i[2:0];
            end
            if (wr_illum) begin
                illum <= hsa_illum_t'(wdata_i[2:0]);
            end
            rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // Writes land in the staged table, frame start copies it live
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pend        <= 1'b0;
            live_active <= 1'b0;
        end else begin
            if (frame_go) begin
                live_active <= next_active;
            end
            // A write in the frame-start cycle keeps the flag set
            if (any_wr) begin
                pend <= 1'b1;
            end else if (frame_go) begin
                pend <= 1'b0;
            end
        end
    end

    for (genvar k = 0; k < NUM_COLORS; k++) begin : g_tab
        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                stage_tab[k] <= NEUTRAL;
                live_tab[k]  <= NEUTRAL;
            end else begin
                if (load_dflt) begin
                    stage_tab[k] <= dflt;
                end else if (sel == 3'(k)) begin
                    if (wr_hue) begin
                        stage_tab[k].hue <= wdata_i[7:0];
                    end
                    if (wr_sat) begin
                        stage_tab[k].sat <= wdata_i[7:0];
                    end
                end
                if (frame_go) begin
                    live_tab[k] <= stage_tab[k];
                end
            end
        end
    end

    // Stage 1: split pixel into gray base, dominant primary, secondary
    logic [2:0] s_prim;
    logic [2:0] s_sec;
    logic [7:0] s_hi;
    logic [7:0] s_md;
    logic [7:0] s_lo;

    always_comb begin
        s_prim = 3'h0;
        s_sec  = 3'h1;
        s_hi   = pix_i.r;
        s_md   = pix_i.g;
        s_lo   = pix_i.b;
        if (pix_i.r >= pix_i.g && pix_i.g >= pix_i.b) begin
            s_prim = 3'h0;
            s_sec  = 3'h1;
        end else if (pix_i.r >= pix_i.b && pix_i.b >= pix_i.g) begin
            s_sec = 3'h5;
            s_md  = pix_i.b;
            s_lo  = pix_i.g;
        end else if (pix_i.g >= pix_i.r && pix_i.r >= pix_i.b) begin
            s_prim = 3'h2;
            s_hi   = pix_i.g;
            s_md   = pix_i.r;
        end else if (pix_i.g >= pix_i.b && pix_i.b >= pix_i.r) begin
            s_prim = 3'h2;
            s_sec  = 3'h3;
            s_hi   = pix_i.g;
            s_md   = pix_i.b;
            s_lo   = pix_i.r;
        end else if (pix_i.b >= pix_i.g && pix_i.g >= pix_i.r) begin
            s_prim = 3'h4;
            s_sec  = 3'h3;
            s_hi   = pix_i.b;
            s_lo   = pix_i.r;
        end else begin
            s_prim = 3'h4;
            s_sec  = 3'h5;
            s_hi   = pix_i.b;
            s_md   = pix_i.r;
            s_lo   = pix_i.g;
        end
    end

    logic       p1_valid;
    logic       p1_sof;
    logic       p1_act;
    hsa_pix_t   p1_raw;
    logic [2:0] p1_prim;
    logic [2:0] p1_sec;
    logic [7:0] p1_c1;
    logic [7:0] p1_c2;
    logic [7:0] p1_lo;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            p1_valid <= 1'b0;
            p1_sof   <= 1'b0;
        end else begin
            p1_valid <= pix_valid_i;
            p1_sof   <= frame_go;
        end
        // Frame start pixel already sees the new settings
        p1_act  <= frame_go ? next_active : live_active;
        p1_raw  <= pix_i;
        p1_prim <= s_prim;
        p1_sec  <= s_sec;
        p1_c1   <= s_hi - s_md;
        p1_c2   <= s_md - s_lo;
        p1_lo   <= s_lo;
    end

    // Stage 2: gain and rotation per component, spread over six corners
    wire hsa_adj_t   adj_p  = live_tab[p1_prim];
    wire hsa_adj_t   adj_s  = live_tab[p1_sec];
    wire [19:0]      sp_p   = hsa_split(p1_c1, adj_p);
    wire [19:0]      sp_s   = hsa_split(p1_c2, adj_s);
    wire [2:0]       nb_p   = hsa_nb(p1_prim, adj_p.hue[7]);
    wire [2:0]       nb_s   = hsa_nb(p1_sec, adj_s.hue[7]);

    logic        p2_valid;
    logic        p2_sof;
    logic        p2_act;
    hsa_pix_t    p2_raw;
    logic [7:0]  p2_lo;
    logic [11:0] p2_w [NUM_COLORS];

    for (genvar k = 0; k < NUM_COLORS; k++) begin : g_wt
        wire [11:0] next_w =
            ((p1_prim == 3'(k)) ? {2'b00, sp_p[19:10]} : 12'h000)
          + ((nb_p    == 3'(k)) ? {2'b00, sp_p[9:0]}   : 12'h000)
          + ((p1_sec  == 3'(k)) ? {2'b00, sp_s[19:10]} : 12'h000)
          + ((nb_s    == 3'(k)) ? {2'b00, sp_s[9:0]}   : 12'h000);
        always_ff @(posedge clk_i) begin
            p2_w[k] <= next_w;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            p2_valid <= 1'b0;
            p2_sof   <= 1'b0;
        end else begin
            p2_valid <= p1_valid;
            p2_sof   <= p1_sof;
        end
        p2_act <= p1_act;
        p2_raw <= p1_raw;
        p2_lo  <= p1_lo;
    end

    // Stage 3: rebuild channels on the gray base, clamp, select bypass
    // Gray input has no colour part, so it comes back unchanged
    wire [11:0] sum_r = {4'h0, p2_lo} + p2_w[0] + p2_w[1] + p2_w[5];
    wire [11:0] sum_g = {4'h0, p2_lo} + p2_w[1] + p2_w[2] + p2_w[3];
    wire [11:0] sum_b = {4'h0, p2_lo} + p2_w[3] + p2_w[4] + p2_w[5];
    wire hsa_pix_t adj_pix = '{
        r: (sum_r > `HSA_CH_MAX) ? 8'hFF : sum_r[7:0],
        g: (sum_g > `HSA_CH_MAX) ? 8'hFF : sum_g[7:0],
        b: (sum_b > `HSA_CH_MAX) ? 8'hFF : sum_b[7:0]};

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pix_valid_o <= 1'b0;
            sof_o       <= 1'b0;
            pix_o       <= '0;
        end else begin
            pix_valid_o <= p2_valid;
            sof_o       <= p2_sof;
            pix_o       <= p2_act ? adj_pix : p2_raw;
        end
    end

endmodule : hsa_top

// File: sim/hsa_top_asserts.sv
/* Checker for the hue/saturation adjust stage: pixel latency, gray
 * pass-through and register read rules. Assumes the hsa_top ports and
 * one clock domain with synchronous active-low reset. */
`include "hsa_defines.svh"
module hsa_top_asserts
    import hsa_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        nrst_i,
    // Register port
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    // Pixel stream
    input wire logic        pix_valid_i,
    input wire logic        sof_i,
    input wire hsa_pix_t    pix_i,
    input wire logic        pix_valid_o,
    input wire logic        sof_o,
    input wire hsa_pix_t    pix_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pend;
    wire  take_sof = pix_valid_i && sof_i;
    wire  gray_in  = pix_valid_i && pix_i.r == pix_i.g && pix_i.g == pix_i.b;
    wire  rd_stat  = rd_i && addr_i == `HSA_REG_STATUS;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Write wins over frame start
    always_ff @(posedge clk_i) begin
        pend <= nrst_i && (wr_i || (pend && !take_sof));
    end

    a_valid_delay: assert property (pix_valid_i |-> ##3 pix_valid_o)
        else $error("output valid late or missing");
    a_bubble_delay: assert property (!pix_valid_i |-> ##3 !pix_valid_o)
        else $error("output valid without input");
    a_sof_delay: assert property (take_sof |-> ##3 sof_o)
        else $error("frame marker not delayed by three");
    a_gray_pass: assert property (gray_in |-> ##3 pix_o == $past(pix_i, 3))
        else $error("gray pixel altered");
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");
    a_sel_range: assert property (rd_i && addr_i == `HSA_REG_SEL |=> rdata_o <= 32'h0000_0005)
        else $error("colour selector out of range");
    a_unmapped_zero: assert property (rd_i && addr_i == 8'h1C |=> rdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_pend_status: assert property (rd_stat |=> rdata_o[1] == $past(pend))
        else $error("pending flag wrong");

    c_frame: cover property (sof_o);
    c_gray: cover property (gray_in);
    c_status: cover property (rd_stat);
endmodule : hsa_top_asserts

bind hsa_top hsa_top_asserts i_hsa_top_asserts (.clk_i, .nrst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .pix_valid_i, .sof_i, .pix_i,
    .pix_valid_o, .sof_o, .pix_o);

// File: sim/hsa_pix_src.sv
/* Upstream pixel source standing in for the white-balanced,
 * matrix-corrected pipeline.
 * Assumes the bench raises send_i for one cycle per pixel. */
module hsa_pix_src
    import hsa_pkg::*;
(
    // Clock
    input  wire logic     clk_i,
    // Bench request
    input  wire logic     send_i,
    input  wire logic     first_i,
    input  wire hsa_pix_t val_i,
    // Stream towards the stage
    output logic          pix_valid_o,
    output logic          sof_o,
    output hsa_pix_t      pix_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pix_valid_o = 1'b0;
        sof_o       = 1'b0;
        pix_o       = 24'h00_0000;
    end
    // Idle cycles carry junk so stale data never passes for valid
    always @(posedge clk_i) begin
        pix_valid_o <= send_i;
        sof_o       <= send_i ? first_i : !sof_o;
        pix_o       <= send_i ? val_i : ~pix_o;
    end
endmodule : hsa_pix_src

// File: sim/test_hue_saturation_adjust.sv
/* Bench for the hue/saturation adjust stage: a table of colour cases,
 * then reset, readback, restore and frame-boundary tests. Assumes the
 * pixel source model and the bound checker. */
`include "hsa_defines.svh"
module test_hue_saturation_adjust
    import hsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] ctrl;
        logic [2:0] sel;
        logic [7:0] hue;
        logic [7:0] sat;
        hsa_pix_t   pin;
        hsa_pix_t   pexp;
    } hsa_row_t;
    localparam hsa_row_t ROWS [14] = '{
        '{3'h1, 3'h0, 8'h00, 8'h80, 24'hFF_0000, 24'hFF_0000},
        '{3'h1, 3'h0, 8'h80, 8'h80, 24'hFF_0000, 24'hFF_FF00},
        '{3'h1, 3'h0, 8'h40, 8'h80, 24'hFF_0000, 24'hFF_0080},
        '{3'h1, 3'h0, 8'hE0, 8'h80, 24'hFF_0000, 24'hFF_4000},
        '{3'h1, 3'h0, 8'h00, 8'h00, 24'hC8_3232, 24'h32_3232},
        '{3'h1, 3'h0, 8'h00, 8'hFF, 24'h64_0000, 24'hC7_0000},
        '{3'h0, 3'h0, 8'h80, 8'h80, 24'hFF_0000, 24'hFF_0000},
        '{3'h5, 3'h0, 8'h80, 8'h80, 24'hFF_0000, 24'hFF_0000},
        '{3'h7, 3'h0, 8'h80, 8'h80, 24'hFF_0000, 24'hFF_FF00},
        '{3'h3, 3'h0, 8'h80, 8'h80, 24'hFF_0000, 24'hFF_FF00},
        '{3'h1, 3'h0, 8'h80, 8'h80, 24'h00_FF00, 24'h00_FF00},
        '{3'h1, 3'h4, 8'h80, 8'h80, 24'h00_00C8, 24'hC8_00C8},
        '{3'h1, 3'h0, 8'h80, 8'h80, 24'hFF_8000, 24'hFF_FF00},
        '{3'h1, 3'h0, 8'h80, 8'h00, 24'h5A_5A5A, 24'h5A_5A5A}
    };
    logic        clk_i;
    logic        nrst_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic        send;
    logic        first;
    hsa_pix_t    val;
    logic        pix_valid_i;
    logic        sof_i;
    hsa_pix_t    pix_i;
    logic        pix_valid_o;
    logic        sof_o;
    hsa_pix_t    pix_o;
    int          fails;
    int          comparisons;

    hsa_pix_src i_hsa_pix_src (.clk_i, .send_i(send), .first_i(first),
        .val_i(val), .pix_valid_o(pix_valid_i), .sof_o(sof_i), .pix_o(pix_i));
    hsa_top i_hsa_top (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .pix_valid_i, .sof_i, .pix_i, .pix_valid_o, .sof_o, .pix_o);

    task automatic complete_run();
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk32(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk32

    task automatic chkpix(input hsa_pix_t e, input hsa_pix_t g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch pix_o expected %h seen %h", e, g);
        end
    endtask : chkpix

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe
    task automatic rg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk32("rdata_o", e, rdata_o);
    endtask : rg

    task automatic px(input hsa_pix_t p, input logic s, input hsa_pix_t e);
        int n;
        @(posedge clk_i);
        send  <= 1'b1;
        first <= s;
        val   <= p;
        @(posedge clk_i);
        send <= 1'b0;
        for (n = 0; n < 8; n++) begin
            @(posedge clk_i);
            #1;
            if (pix_valid_o === 1'b1) break;
        end
        if (n == 8) begin
            fails++;
            complete_run();
        end else begin
            chkpix(e, pix_o);
            chk32("sof_o", 32'(s), 32'(sof_o));
        end
    endtask : px

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        nrst_i      = 1'b0;
        addr_i      = 8'h00;
        wdata_i     = 32'h0000_0000;
        wr_i        = 1'b0;
        rd_i        = 1'b0;
        send        = 1'b0;
        first       = 1'b0;
        val         = 24'h00_0000;
        fails       = 0;
        comparisons = 0;
        repeat (20) @(posedge clk_i);
        #1;
        chk32("rdata_o", 32'h0000_0000, rdata_o);
        chk32("pix_valid_o", 32'h0000_0000, 32'(pix_valid_o));
        @(posedge clk_i);
        nrst_i <= 1'b1;
        rg(`HSA_REG_SAT, 32'h0000_0080);
        rg(`HSA_REG_ILLUM, 32'h0000_0000);
        foreach (ROWS[i]) begin
            wr(`HSA_REG_ILLUM, 32'h0000_0004);
            wr(`HSA_REG_CTRL, 32'(ROWS[i].ctrl));
            wr(`HSA_REG_SEL, 32'(ROWS[i].sel));
            wr(`HSA_REG_HUE, 32'(ROWS[i].hue));
            wr(`HSA_REG_SAT, 32'(ROWS[i].sat));
            px(ROWS[i].pin, 1'b1, ROWS[i].pexp);
        end
        // Pairs stay apart; out-of-range selector is dropped
        wr(`HSA_REG_SEL, 32'h0000_0002);
        wr(`HSA_REG_HUE, 32'h0000_00E0);
        wr(`HSA_REG_SEL, 32'h0000_0003);
        wr(`HSA_REG_HUE, 32'h0000_0011);
        wr(`HSA_REG_SEL, 32'h0000_0002);
        wr(`HSA_REG_SEL, 32'h0000_0006);
        rg(`HSA_REG_HUE, 32'h0000_00E0);
        rg(`HSA_REG_SEL, 32'h0000_0002);
        rg(8'h1C, 32'h0000_0000);
        wr(`HSA_REG_ILLUM, 32'h0000_0004);
        wr(`HSA_REG_SEL, 32'h0000_0000);
        wr(`HSA_REG_SAT, 32'h0000_0010);
        wr(`HSA_REG_RESTORE, 32'h0000_0001);
        rg(`HSA_REG_SAT, 32'h0000_0080);
        // Mid-frame change must wait for the next frame start
        wr(`HSA_REG_CTRL, 32'h0000_0001);
        px(24'hFF_0000, 1'b1, 24'hFF_0000);
        wr(`HSA_REG_SAT, 32'h0000_0000);
        rg(`HSA_REG_STATUS, 32'h0000_0003);
        px(24'hFF_0000, 1'b0, 24'hFF_0000);
        px(24'hFF_0000, 1'b1, 24'h00_0000);
        rg(`HSA_REG_STATUS, 32'h0000_0001);
        // Mid-run reset drops live settings and the illuminant
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk32("pix_valid_o", 32'h0000_0000, 32'(pix_valid_o));
        @(posedge clk_i);
        nrst_i <= 1'b1;
        rg(`HSA_REG_STATUS, 32'h0000_0000);
        rg(`HSA_REG_ILLUM, 32'h0000_0000);
        rg(`HSA_REG_SAT, 32'h0000_0080);
        px(24'hFF_0000, 1'b1, 24'hFF_0000);
        complete_run();
    end
endmodule : test_hue_saturation_adjust
